// *** dv/conv_source.sv ***
// Raw conversion source feeding result sets to the checker block.
// Assumes the bench calls send from its main sequence.
`timescale 1ns/10ps
module conv_source (
   input wire logic sys_clk_i,
   output logic conv_valid_o,
   output logic [159:0] conv_data_o
);
   initial begin
      conv_valid_o = 1'b0;
      conv_data_o = '0;
   end
   // every raw sample
   // Two sets back to back; data inverts after, never a stale copy
   task send(input logic [159:0] a, input logic [159:0] b);
      @(posedge sys_clk_i);
      conv_valid_o <= 1'b1;
      conv_data_o <= a;
      @(posedge sys_clk_i);
      conv_data_o <= b;
      @(posedge sys_clk_i);
      conv_valid_o <= 1'b0;
      conv_data_o <= ~b;
   endtask
endmodule // conv_source

// *** dv/range_properties.sv ***
// Port checker for the range limit block, bound to its top module.
// Assumes one clock and a one-wait-cycle register bus answer.
`timescale 1ns/10ps
module range_props (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [range_pkg::DATA_W-1:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire logic conv_valid_i,
   input wire logic irq_o
);
   import range_pkg::*;
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   logic req;
   logic wr_done;
   // A write lands only at its waitrequest-low edge
   assign req = avs_read_i || avs_write_i;
   assign wr_done = avs_write_i && !avs_waitrequest_o;
   wait_answer_a: assert property (req && avs_waitrequest_o |=>
      !avs_waitrequest_o) else $error("bus answer late");
   wait_pulse_a: assert property (!avs_waitrequest_o |=>
      avs_waitrequest_o) else $error("wait low too long");
   idle_wait_a: assert property (!req |=> avs_waitrequest_o)
      else $error("answer without request");
   rdata_hold_a: assert property (!avs_read_i |=>
      $stable(avs_readdata_o)) else $error("read data moved");
   irq_sticky_a: assert property (irq_o && !wr_done |=> irq_o)
      else $error("flag lost without clear");
   irq_cause_a: assert property ($rose(irq_o) |->
      $past(conv_valid_i, 2) || $past(wr_done) || $past(wr_done, 2))
      else $error("irq without cause");
   cover property (avs_read_i && !avs_waitrequest_o);
   cover property (wr_done);
   cover property ($rose(irq_o));
endmodule // range_props

bind channel_range_limit_checker range_props u_props (
   .sys_clk_i(sys_clk_i),
   .rst_n_i(rst_n_i),
   .avs_read_i(avs_read_i),
   .avs_write_i(avs_write_i),
   .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o),
   .conv_valid_i(conv_valid_i),
   .irq_o(irq_o)
);

// *** dv/testbench.sv ***
// Self-checking bench for the range limit block over Avalon-MM.
// Assumes one wait cycle per access and flags two edges after a set.
`timescale 1ns/10ps
module testbench;
   import range_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [ADDR_W-1:0] addr = '0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [DATA_W-1:0] wdata = '0;
   logic [DATA_W-1:0] rdata;
   logic wreq;
   logic irq;
   logic cv;
   logic [159:0] cd;
   logic [159:0] da;
   int mismatches = 0;
   int n_checks = 0;
   always #12.5 clk = ~clk;
   channel_range_limit_checker u_dut (.sys_clk_i(clk), .rst_n_i(rst_n),
      .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wdata), .avs_byteenable_i(4'hf),
      .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
      .conv_valid_i(cv), .conv_data_i(cd), .irq_o(irq));
   conv_source u_src (.sys_clk_i(clk), .conv_valid_o(cv),
      .conv_data_o(cd));
   task report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // Request held until waitrequest is seen low at an edge
   task access(input logic w, input logic [7:0] idx,
      input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clk);
      addr <= {idx, 2'b00};
      rd <= !w;
      wr <= w;
      wdata <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wreq !== 1'b0 && n < 50);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      if (n >= 50) begin
         mismatches++;
         report_and_stop();
      end
   endtask
   task rchk(input logic [7:0] idx, input logic [31:0] exp);
      logic [31:0] q;
      access(1'b0, idx, '0, q);
      chk(q, exp);
   endtask
   task wreg(input logic [7:0] idx, input logic [31:0] d);
      logic [31:0] q;
      access(1'b1, idx, d, q);
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      // Reset limits of every channel
      for (int c = 0; c < NUM_CHAN; c++) begin
         rchk(HIGH_LIMIT_IDX[c], 32'h0007ffff);
         rchk(LOW_LIMIT_IDX[c], 32'h00f80000);
      end
      rchk(8'h10, 32'h0);
      wreg(HIGH_MASK_IDX, 32'hff);
      wreg(LOW_MASK_IDX, 32'hff);
      // Full-scale codes equal the defaults, so nothing flags
      for (int c = 0; c < NUM_CHAN; c++) da[20*c +: 20] = 20'h7ffff;
      u_src.send(da, {NUM_CHAN{20'h80000}});
      rchk(HIGH_FLAG_IDX, 32'h0);
      rchk(LOW_FLAG_IDX, 32'h0);
      wreg(HIGH_LIMIT_IDX[2], 32'h000100);
      wreg(LOW_LIMIT_IDX[5], 32'hffff00);
      rchk(LOW_LIMIT_IDX[5], 32'h00ffff00);
      // Out-of-range set, then an in-range set right behind it
      da = '0;
      da[40 +: 20] = 20'h00101;
      da[100 +: 20] = 20'hffeff;
      u_src.send(da, {20'h0, 20'h0, 20'hfff00, 40'h0, 20'h00100,
         40'h0});
      // Flag and irq land on the edge where the send returns
      @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      rchk(HIGH_FLAG_IDX, 32'h04);
      rchk(LOW_FLAG_IDX, 32'h20);
      wreg(HIGH_FLAG_IDX, 32'h04);
      rchk(HIGH_FLAG_IDX, 32'h0);
      chk({31'h0, irq}, 32'h1);
      wreg(LOW_FLAG_IDX, 32'h20);
      @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      // Checking off drops strobes; masked flags keep irq low
      wreg(HIGH_MASK_IDX, 32'h00);
      wreg(LOW_MASK_IDX, 32'h00);
      wreg(CONTROL_IDX, 32'h0);
      rchk(CONTROL_IDX, 32'h0);
      u_src.send(da, da);
      rchk(HIGH_FLAG_IDX, 32'h0);
      wreg(CONTROL_IDX, 32'h1);
      u_src.send(da, da);
      @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      rchk(HIGH_FLAG_IDX, 32'h04);
      rchk(LOW_FLAG_IDX, 32'h20);
      // Unmasking a standing flag raises irq on the same edge as the mask write
      wreg(HIGH_MASK_IDX, 32'h04);
      @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      report_and_stop();
   end
endmodule // testbench

// *** rtl/channel_range_limit_checker.sv ***
// Per-channel out-of-range detector with Avalon-MM register access.
// Assumes raw, pre-averaging conversion results arrive as a strobe
// with all eight 20-bit codes, synchronous to sys_clk_i.
//
// Operation
// - Compare each result to own 20-bit limits
// - Out-of-range result sets channel status bit
// - Check every raw sample, even when oversampling
// - Limits reset to bipolar full scale
// - Host-written signed limits used thereafter
`timescale 1ns/10ps
module channel_range_limit_checker (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic [range_pkg::ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [range_pkg::DATA_W-1:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [range_pkg::DATA_W-1:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic conv_valid_i,
   input wire logic [range_pkg::NUM_CHAN*range_pkg::CODE_W-1:0] conv_data_i,
   output logic irq_o
);
   import range_pkg::*;

   typedef struct packed {
      code_bank_t high_lim;
      code_bank_t low_lim;
      logic [NUM_CHAN-1:0] high_flag;
      logic [NUM_CHAN-1:0] low_flag;
      logic [NUM_CHAN-1:0] high_mask;
      logic [NUM_CHAN-1:0] low_mask;
      logic check_en;
      logic waitreq;
      logic [DATA_W-1:0] rdata;
      logic irq;
   } top_state_t;

   top_state_t st;
   top_state_t next_st;
   limit_cmp_if cmp_bus ();

   limit_compare u_compare (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .cmp(cmp_bus.checker_side)
   );

   // raw samples, not averages, feed the comparators
   assign cmp_bus.conv_valid = conv_valid_i & st.check_en;
   assign cmp_bus.conv_data = code_bank_t'(conv_data_i);
   assign cmp_bus.high_lim = st.high_lim;
   assign cmp_bus.low_lim = st.low_lim;

   // Sign-extend a stored code to its 24-bit register image
   function automatic logic [DATA_W-1:0] limit_image(
      input logic [CODE_W-1:0] code);
      limit_image = {8'h00, {(LIMIT_REG_W-CODE_W){code[CODE_W-1]}}, code};
   endfunction

   // Merge write data into a register image lane by lane
   function automatic logic [DATA_W-1:0] merge_lanes(
      input logic [DATA_W-1:0] old_val,
      input logic [DATA_W-1:0] wdata,
      input logic [3:0] be);
      logic [DATA_W-1:0] res;
      res = old_val;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            res[b*8 +: 8] = wdata[b*8 +: 8];
         end
      end
      merge_lanes = res;
   endfunction

   logic [7:0] word_idx;
   logic rd_hit;
   logic wr_take;
   logic [DATA_W-1:0] rd_val;
   logic [NUM_CHAN-1:0] high_clr;
   logic [NUM_CHAN-1:0] low_clr;
   logic [DATA_W-1:0] merged;
   logic [NUM_CHAN-1:0] high_sel;
   logic [NUM_CHAN-1:0] low_sel;
   logic [DATA_W-1:0] rd_chain [NUM_CHAN+1];
   code_bank_t next_high_code;
   code_bank_t next_low_code;

   assign word_idx = avs_address_i[ADDR_W-1:2];
   // Lane merge against the addressed image; only used on a write
   assign merged = merge_lanes(rd_val, avs_writedata_i, avs_byteenable_i);

   // Per-channel decode, read image and limit update, one slice each.
   // Read path is an OR chain, safe since at most one slice is selected.
   assign rd_chain[0] = '0;
   for (genvar c = 0; c < NUM_CHAN; c++) begin : g_lim
      logic [DATA_W-1:0] sel_img;
      assign high_sel[c] = (word_idx == HIGH_LIMIT_IDX[c]);
      assign low_sel[c] = (word_idx == LOW_LIMIT_IDX[c]);
      // Image of whichever limit word of this channel is addressed
      always_comb begin
         sel_img = '0;
         if (high_sel[c]) begin
            sel_img = limit_image(st.high_lim[c]);
         end
         if (low_sel[c]) begin
            sel_img = limit_image(st.low_lim[c]);
         end
      end
      assign rd_chain[c+1] = rd_chain[c] | sel_img;
      assign next_high_code[c] = (wr_take && high_sel[c])
         ? merged[CODE_W-1:0] : st.high_lim[c];
      assign next_low_code[c] = (wr_take && low_sel[c])
         ? merged[CODE_W-1:0] : st.low_lim[c];
   end

   // Read mux; unmapped words read as zero
   always_comb begin
      rd_val = rd_chain[NUM_CHAN];
      case (word_idx)
         HIGH_FLAG_IDX: rd_val = {24'h000000, st.high_flag};
         LOW_FLAG_IDX: rd_val = {24'h000000, st.low_flag};
         HIGH_MASK_IDX: rd_val = {24'h000000, st.high_mask};
         LOW_MASK_IDX: rd_val = {24'h000000, st.low_mask};
         CONTROL_IDX: rd_val = {31'h00000000, st.check_en};
         default: rd_val = rd_chain[NUM_CHAN];
      endcase
   end

   // One wait cycle: first edge loads data, second edge completes
   assign rd_hit = avs_read_i & st.waitreq;
   assign wr_take = avs_write_i & ~st.waitreq;

   // Write-one-to-clear strobes for the flag registers
   always_comb begin
      high_clr = '0;
      low_clr = '0;
      if (wr_take && avs_byteenable_i[0]) begin
         if (word_idx == HIGH_FLAG_IDX) begin
            high_clr = avs_writedata_i[NUM_CHAN-1:0];
         end
         if (word_idx == LOW_FLAG_IDX) begin
            low_clr = avs_writedata_i[NUM_CHAN-1:0];
         end
      end
   end

   always_comb begin
      next_st = st;
      // Bus handshake
      if ((avs_read_i || avs_write_i) && st.waitreq) begin
         next_st.waitreq = 1'b0;
      end else begin
         next_st.waitreq = 1'b1;
      end
      if (rd_hit) begin
         next_st.rdata = rd_val;
      end
      next_st.high_lim = next_high_code;
      next_st.low_lim = next_low_code;
      if (wr_take) begin
         if (word_idx == HIGH_MASK_IDX) begin
            next_st.high_mask = merged[NUM_CHAN-1:0];
         end
         if (word_idx == LOW_MASK_IDX) begin
            next_st.low_mask = merged[NUM_CHAN-1:0];
         end
         if (word_idx == CONTROL_IDX) begin
            next_st.check_en = merged[CTRL_CHECK_EN_BIT];
         end
      end
      // sticky, set beats a same-cycle clear
      next_st.high_flag = (st.high_flag & ~high_clr)
         | (cmp_bus.hit_high & {NUM_CHAN{cmp_bus.hit_valid}});
      next_st.low_flag = (st.low_flag & ~low_clr)
         | (cmp_bus.hit_low & {NUM_CHAN{cmp_bus.hit_valid}});
      // Level interrupt from the unmasked flags
      next_st.irq = |(next_st.high_flag & next_st.high_mask)
         | |(next_st.low_flag & next_st.low_mask);
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st.high_lim <= {NUM_CHAN{HIGH_LIMIT_RST}};
         st.low_lim <= {NUM_CHAN{LOW_LIMIT_RST}};
         st.high_flag <= '0;
         st.low_flag <= '0;
         st.high_mask <= MASK_RST;
         st.low_mask <= MASK_RST;
         st.check_en <= CHECK_EN_RST;
         st.waitreq <= 1'b1;
         st.rdata <= '0;
         st.irq <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   // All outputs straight from the state register
   assign avs_readdata_o = st.rdata;
   assign avs_waitrequest_o = st.waitreq;
   assign irq_o = st.irq;
endmodule // channel_range_limit_checker

// *** rtl/limit_cmp_if.sv ***
// Carries results, limits and compare outcomes between the register
// block and the comparator bank. Assumes one shared clock.
`timescale 1ns/10ps
interface limit_cmp_if;
   import range_pkg::*;
   logic conv_valid;
   code_bank_t conv_data;
   code_bank_t high_lim;
   code_bank_t low_lim;
   logic hit_valid;
   logic [NUM_CHAN-1:0] hit_high;
   logic [NUM_CHAN-1:0] hit_low;

   modport owner (
      output conv_valid, conv_data, high_lim, low_lim,
      input hit_valid, hit_high, hit_low
   );
   modport checker_side (
      input conv_valid, conv_data, high_lim, low_lim,
      output hit_valid, hit_high, hit_low
   );
endinterface // limit_cmp_if

// *** rtl/limit_compare.sv ***
// Bank of signed comparators, one per channel, registered once.
// Assumes conv_valid is a one-cycle strobe per conversion set.
`timescale 1ns/10ps
module limit_compare (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   limit_cmp_if.checker_side cmp
);
   import range_pkg::*;

   typedef struct packed {
      logic hit_valid;
      logic [NUM_CHAN-1:0] hit_high;
      logic [NUM_CHAN-1:0] hit_low;
   } cmp_state_t;

   cmp_state_t st;
   cmp_state_t next_st;
   logic [NUM_CHAN-1:0] above;
   logic [NUM_CHAN-1:0] below;

   for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
      assign above[c] = $signed(cmp.conv_data[c]) > $signed(cmp.high_lim[c]);
      assign below[c] = $signed(cmp.conv_data[c]) < $signed(cmp.low_lim[c]);
   end

   // Outcomes only count on a conversion strobe
   always_comb begin
      next_st = st;
      next_st.hit_valid = cmp.conv_valid;
      next_st.hit_high = cmp.conv_valid ? above : '0;
      next_st.hit_low = cmp.conv_valid ? below : '0;
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign cmp.hit_valid = st.hit_valid;
   assign cmp.hit_high = st.hit_high;
   assign cmp.hit_low = st.hit_low;
endmodule // limit_compare

// *** rtl/range_pkg.sv ***
// Constants and types for the per-channel range limit checker.
// Assumes an Avalon-MM byte address, 32-bit data, one 40 MHz clock.
package range_pkg;
   localparam int NUM_CHAN = 8;
   localparam int CODE_W = 20;
   localparam int ADDR_W = 10;
   localparam int DATA_W = 32;
   localparam int LIMIT_REG_W = 24;

   // Register indices; byte address is four times the index
   localparam logic [NUM_CHAN-1:0][7:0] HIGH_LIMIT_IDX = {
      8'hb0, 8'h9e, 8'h8c, 8'h7a, 8'h68, 8'h56, 8'h44, 8'h32};
   localparam logic [NUM_CHAN-1:0][7:0] LOW_LIMIT_IDX = {
      8'hb3, 8'ha1, 8'h8f, 8'h7d, 8'h6b, 8'h59, 8'h47, 8'h35};
   localparam logic [7:0] HIGH_FLAG_IDX = 8'hc0;
   localparam logic [7:0] LOW_FLAG_IDX = 8'hc1;
   localparam logic [7:0] HIGH_MASK_IDX = 8'hc2;
   localparam logic [7:0] LOW_MASK_IDX = 8'hc3;
   localparam logic [7:0] CONTROL_IDX = 8'hc4;

   // Field position of the check enable in the control register
   localparam int CTRL_CHECK_EN_BIT = 0;

   // Reset values: limits at bipolar positive and negative full scale, masks clear, checking on
   localparam logic [CODE_W-1:0] HIGH_LIMIT_RST = 20'h7ffff;
   localparam logic [CODE_W-1:0] LOW_LIMIT_RST = 20'h80000;
   localparam logic [NUM_CHAN-1:0] MASK_RST = 8'h00;
   localparam logic CHECK_EN_RST = 1'b1;

   // Cycles from a conversion strobe to the registered compare outcome
   localparam int COMPARE_LATENCY = 1;

   typedef logic [NUM_CHAN-1:0][CODE_W-1:0] code_bank_t;
endpackage
